// *** rtl/rspm_top.sv ***
// Purpose: reset state, shared pin function and pll input mode control
// Assumes: all inputs synchronous to clk_in; por_in from the supply monitor
// Notes: APB slave, registers answer after one wait cycle
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
module rspm_top (
    input logic clk_in,
    input logic sys_rst_in,
    input logic clk_en_in,
    input logic psel_in,
    input logic penable_in,
    input logic pwrite_in,
    input logic [7:0] paddr_in,
    input logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input logic chip_enable_in,
    input logic por_in,
    input logic clock_stop_in,
    input logic adc_cmp_in,
    output logic [5:0] adc_tap_out,
    output logic [5:0] adc_mux_out,
    output logic [7:0] pin_gpio_out,
    output logic [7:0] pin_count_out,
    output logic [7:0] pin_adc_out,
    output logic lo_low_sel_out,
    output logic lo_high_sel_out,
    output logic lo_low_pd_out,
    output logic lo_high_pd_out,
    output logic swallow_en_out,
    output logic osc_run_out,
    output logic backup_out,
    output logic restart_out,
    output logic [12:0] restart_addr_out,
    output logic timer_carry_out,
    output logic irq_out
);
    rspm_pkg::rspm_state_t state_reg;
    logic ce_q_reg, tc_reg;
    logic [15:0] pin_func_reg;
    logic [3:0] chan_reg, mode_reg, applied_reg;
    logic por_evt, stop_evt, ce_evt, wipe;
    logic setup_ph, acc, wr_go, hit;
    logic [31:0] rd_data;
    logic [3:0] ev_set, ev_clr, status, mask;
    logic mask_wr, adc_start, adc_busy, adc_done;
    logic [5:0] adc_res;
    logic lo_active, use_low, use_high;

    // reset sources, power-on reset outranks clock stop outranks chip enable
    assign por_evt = clk_en_in && por_in;
    assign stop_evt = clk_en_in && clock_stop_in && !por_in;
    assign ce_evt = clk_en_in && chip_enable_in && !ce_q_reg
        && !por_in && !clock_stop_in;
    assign wipe = sys_rst_in || por_evt;

    // APB: first access cycle raises pready, second completes
    assign setup_ph = psel_in && penable_in && !pready_out;
    assign acc = clk_en_in && psel_in && penable_in && pready_out;
    // registers are retained, not written, while in backup
    assign wr_go = acc && pwrite_in && (state_reg == rspm_pkg::ST_RUN);

    always_comb begin
        rd_data = 32'h0000_0000;
        hit = 1'b1;
        if (paddr_in == rspm_pkg::OFS_PINF) begin
            rd_data[15:0] = pin_func_reg;
        end else if (paddr_in == rspm_pkg::OFS_STAT) begin
            rd_data[3:0] = status;
        end else if (paddr_in == rspm_pkg::OFS_MASK) begin
            rd_data[3:0] = mask;
        end else if (paddr_in == rspm_pkg::OFS_ADC) begin
            rd_data[5:0] = adc_res;
            rd_data[8] = adc_busy;
        end else if (paddr_in == rspm_pkg::OFS_SYS) begin
            rd_data[rspm_pkg::SYS_TC] = tc_reg;
            rd_data[rspm_pkg::SYS_BACKUP] = (state_reg == rspm_pkg::ST_BACKUP);
            rd_data[rspm_pkg::SYS_PLL] = (applied_reg != rspm_pkg::PLL_OFF);
        end else if (paddr_in == rspm_pkg::OFS_CHAN) begin
            rd_data[3:0] = chan_reg;
        end else if (paddr_in == rspm_pkg::OFS_MODE) begin
            rd_data[3:0] = mode_reg;
        end else begin
            hit = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            pready_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end else if (clk_en_in) begin
            pready_out <= setup_ph;
            if (setup_ph) begin
                prdata_out <= pwrite_in ? 32'h0000_0000 : rd_data;
                pslverr_out <= !hit;
            end else begin
                prdata_out <= 32'h0000_0000;
                pslverr_out <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ce_q_reg <= 1'b1;
        end else if (clk_en_in) begin
            ce_q_reg <= chip_enable_in;
        end
    end

    // shared pin functions
    always_ff @(posedge clk_in) begin
        if (wipe) begin
            pin_func_reg <= rspm_pkg::PINF_RST;
        end else if (stop_evt) begin
            pin_func_reg <= rspm_pkg::PINF_RST;
        end else if (ce_evt) begin
            pin_func_reg <= pin_func_reg;
        end else if (wr_go && paddr_in == rspm_pkg::OFS_PINF) begin
            pin_func_reg <= pwdata_in[15:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (wipe) begin
            chan_reg <= rspm_pkg::CHAN_RST;
        end else if (wr_go && paddr_in == rspm_pkg::OFS_CHAN) begin
            chan_reg <= pwdata_in[3:0];
        end
    end

    // mode register keeps its value through clock stop; applied mode does not
    always_ff @(posedge clk_in) begin
        if (wipe) begin
            mode_reg <= rspm_pkg::PLL_OFF;
        end else if (wr_go && paddr_in == rspm_pkg::OFS_MODE && !stop_evt && !ce_evt) begin
            mode_reg <= pwdata_in[3:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (wipe) begin
            applied_reg <= rspm_pkg::PLL_OFF;
        end else if (stop_evt) begin
            applied_reg <= rspm_pkg::PLL_OFF;
        end else if (ce_evt) begin
            applied_reg <= mode_reg;
        end else if (wr_go && paddr_in == rspm_pkg::OFS_MODE) begin
            applied_reg <= pwdata_in[3:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (wipe) begin
            tc_reg <= rspm_pkg::TC_POR;
        end else if (ce_evt) begin
            tc_reg <= rspm_pkg::TC_CE;
        end
    end

    // backup is left only by a chip-enable reset, power-on reset or sys_rst_in
    always_ff @(posedge clk_in) begin
        if (wipe) begin
            state_reg <= rspm_pkg::ST_RUN;
        end else if (clk_en_in) begin
            case (state_reg)
                rspm_pkg::ST_RUN: begin
                    if (stop_evt && !chip_enable_in) begin
                        state_reg <= rspm_pkg::ST_BACKUP;
                    end
                end
                rspm_pkg::ST_BACKUP: begin
                    if (ce_evt) begin
                        state_reg <= rspm_pkg::ST_RUN;
                    end
                end
                default: begin
                    state_reg <= rspm_pkg::ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            osc_run_out <= 1'b1;
            backup_out <= 1'b0;
            restart_out <= 1'b1;
            restart_addr_out <= rspm_pkg::RESTART_ADDR;
            timer_carry_out <= rspm_pkg::TC_POR;
        end else if (clk_en_in) begin
            osc_run_out <= (state_reg == rspm_pkg::ST_RUN);
            backup_out <= (state_reg == rspm_pkg::ST_BACKUP);
            restart_out <= por_evt || ce_evt;
            restart_addr_out <= rspm_pkg::RESTART_ADDR;
            timer_carry_out <= tc_reg;
        end
    end

    // per-pin function decode and converter input selection
    genvar gi;
    generate
        for (gi = 0; gi < rspm_pkg::NPIN; gi++) begin : g_pin
            always_ff @(posedge clk_in) begin
                if (sys_rst_in) begin
                    pin_gpio_out[gi] <= 1'b1;
                    pin_count_out[gi] <= 1'b0;
                    pin_adc_out[gi] <= 1'b0;
                end else if (clk_en_in) begin
                    pin_gpio_out[gi] <= pin_func_reg[2*gi+:2] == rspm_pkg::PF_GPIO;
                    pin_count_out[gi] <= pin_func_reg[2*gi+:2] == rspm_pkg::PF_COUNT;
                    pin_adc_out[gi] <= pin_func_reg[2*gi+:2] == rspm_pkg::PF_ADC;
                end
            end
            if (gi < rspm_pkg::ADC_CH) begin : g_ch
                always_ff @(posedge clk_in) begin
                    if (sys_rst_in) begin
                        adc_mux_out[gi] <= 1'b0;
                    end else if (clk_en_in) begin
                        adc_mux_out[gi] <= chan_reg == 4'(gi);
                    end
                end
            end
        end
    endgenerate

    // pll input steering; the 4-bit mode field leaves codes above 3 as off
    assign lo_active = chip_enable_in && (state_reg == rspm_pkg::ST_RUN);
    assign use_low = (applied_reg == rspm_pkg::DIRECT_DIV_LOW_BAND)
        || (applied_reg == rspm_pkg::SWALLOW_DIV_MID_BAND);
    assign use_high = applied_reg == rspm_pkg::SWALLOW_DIV_TOP_BAND;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            lo_low_sel_out <= 1'b0;
            lo_high_sel_out <= 1'b0;
            lo_low_pd_out <= 1'b1;
            lo_high_pd_out <= 1'b1;
            swallow_en_out <= 1'b0;
        end else if (clk_en_in) begin
            lo_low_sel_out <= lo_active && use_low;
            lo_high_sel_out <= lo_active && use_high;
            lo_low_pd_out <= !(lo_active && use_low);
            lo_high_pd_out <= !(lo_active && use_high);
            swallow_en_out <= lo_active && (applied_reg == rspm_pkg::SWALLOW_DIV_MID_BAND
                || use_high);
        end
    end

    // events and interrupt
    assign ev_set[rspm_pkg::EV_POR] = por_evt;
    assign ev_set[rspm_pkg::EV_CE] = ce_evt;
    assign ev_set[rspm_pkg::EV_STOP] = stop_evt;
    assign ev_set[rspm_pkg::EV_ADC] = adc_done;
    assign ev_clr = (wr_go && paddr_in == rspm_pkg::OFS_STAT) ? pwdata_in[3:0] : 4'h0;
    assign mask_wr = wr_go && paddr_in == rspm_pkg::OFS_MASK;
    assign adc_start = wr_go && paddr_in == rspm_pkg::OFS_ADC && pwdata_in[0];

    rspm_evt u_evt (
        .clk_in(clk_in),
        .rst_in(sys_rst_in),
        .en_in(clk_en_in),
        .set_in(ev_set),
        .clr_in(ev_clr),
        .mask_wr_in(mask_wr),
        .mask_in(pwdata_in[3:0]),
        .status_out(status),
        .mask_out(mask),
        .irq_out(irq_out)
    );

    // converter; a clock stop abandons a conversion in flight
    rspm_sar u_sar (
        .clk_in(clk_in),
        .rst_in(wipe),
        .en_in(clk_en_in),
        .abort_in(clock_stop_in),
        .start_in(adc_start),
        .cmp_in(adc_cmp_in),
        .tap_out(adc_tap_out),
        .result_out(adc_res),
        .busy_out(adc_busy),
        .done_out(adc_done)
    );

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    property p_chan_sel;
        (clk_en_in && chan_reg < 4'h6) |=> (adc_mux_out == 6'(1 << $past(chan_reg)));
    endproperty
    a_chan_sel: assert property (p_chan_sel) else $error("channel decode wrong");
    property p_chan_wr;
        (wr_go && paddr_in == rspm_pkg::OFS_CHAN) |=> (chan_reg == $past(pwdata_in[3:0]));
    endproperty
    a_chan_wr: assert property (p_chan_wr) else $error("channel write lost");
    // pin outputs only follow the function register in cycles that were enabled
    sequence s_pins_plain;
        (pin_func_reg == rspm_pkg::PINF_RST) ##1 (pin_gpio_out == 8'hFF || !$past(clk_en_in));
    endsequence
    property p_por_pins;
        (por_evt || stop_evt) |=> s_pins_plain;
    endproperty
    a_por_pins: assert property (p_por_pins) else $error("pins not plain");

    property p_ce_keep;
        ce_evt |=> $stable(pin_func_reg);
    endproperty
    a_ce_keep: assert property (p_ce_keep) else $error("pin function lost");
    property p_backup;
        (stop_evt && !chip_enable_in && state_reg == rspm_pkg::ST_RUN)
            |=> (state_reg == rspm_pkg::ST_BACKUP) ##1 (!osc_run_out || !$past(clk_en_in));
    endproperty
    a_backup: assert property (p_backup) else $error("no backup entry");
    property p_restart;
        por_evt |=> (restart_out && restart_addr_out == 13'h0000 && mode_reg == 4'h0);
    endproperty
    a_restart: assert property (p_restart) else $error("no restart");

    property p_tc;
        (por_evt |=> tc_reg == 1'b0) and (ce_evt |=> tc_reg == 1'b1);
    endproperty
    a_tc: assert property (p_tc) else $error("timer carry wrong");
    property p_swallow;
        (clk_en_in && lo_active && applied_reg == 4'h1) |=> (!swallow_en_out && lo_low_sel_out);
    endproperty
    a_swallow: assert property (p_swallow) else $error("division mode wrong");
    property p_pd_unsel;
        (clk_en_in && lo_active && applied_reg == 4'h3)
            |=> (lo_low_pd_out && !lo_high_pd_out);
    endproperty
    a_pd_unsel: assert property (p_pd_unsel) else $error("unselected not pulled");

    property p_pd_off;
        (clk_en_in && (!chip_enable_in || applied_reg == 4'h0))
            |=> (lo_low_pd_out && lo_high_pd_out);
    endproperty
    a_pd_off: assert property (p_pd_off) else $error("inputs not pulled down");
    property p_stop_pll;
        (por_evt || stop_evt) |=> (applied_reg == 4'h0);
    endproperty
    a_stop_pll: assert property (p_stop_pll) else $error("pll not off");

    property p_ce_pll;
        ce_evt |=> (applied_reg == $past(mode_reg));
    endproperty
    a_ce_pll: assert property (p_ce_pll) else $error("pll mode not applied");
endmodule

// *** rtl/rspm_pkg.sv ***
// Purpose: shared constants for the reset state and pin mode controller
// Assumes: APB with 32-bit data, byte addresses on paddr
// Notes: register offsets and reset markers are shared by top and bench
package rspm_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // printed register-file indices, byte address is four times the index
    localparam logic [7:0] IDX_CHAN = 8'h14;
    localparam logic [7:0] IDX_MODE = 8'h21;
    localparam logic [7:0] OFS_CHAN = 8'h50;
    localparam logic [7:0] OFS_MODE = 8'h84;
    localparam logic [7:0] OFS_PINF = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_ADC = 8'h0C;
    localparam logic [7:0] OFS_SYS = 8'h10;

    localparam int ADC_BITS = 6;
    localparam int ADC_CH = 6;
    localparam int NPIN = 8;
    localparam int PINF_W = 2 * NPIN;
    localparam int REG_W = 4;
    localparam int EVT_W = 4;
    localparam logic [5:0] ADC_MSB = 6'h20;

    // pin function codes, two bits per shared pin
    localparam logic [1:0] PF_GPIO = 2'h0;
    localparam logic [1:0] PF_COUNT = 2'h1;
    localparam logic [1:0] PF_ADC = 2'h2;
    localparam logic [15:0] PINF_RST = 16'h0000;
    localparam logic [3:0] CHAN_RST = 4'h0;

    // pll division mode codes
    localparam logic [3:0] PLL_OFF = 4'h0;
    localparam logic [3:0] DIRECT_DIV_LOW_BAND = 4'h1;
    localparam logic [3:0] SWALLOW_DIV_MID_BAND = 4'h2;
    localparam logic [3:0] SWALLOW_DIV_TOP_BAND = 4'h3;

    // timer carry marker after power-on reset and after chip-enable reset
    localparam logic TC_POR = 1'b0;
    localparam logic TC_CE = 1'b1;
    localparam logic [12:0] RESTART_ADDR = 13'h0000;

    // status bit positions
    localparam int EV_POR = 0;
    localparam int EV_CE = 1;
    localparam int EV_STOP = 2;
    localparam int EV_ADC = 3;

    // system status bit positions
    localparam int SYS_TC = 0;
    localparam int SYS_BACKUP = 1;
    localparam int SYS_PLL = 2;

    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_BACKUP = 2'b10
    } rspm_state_t;
endpackage

// *** rtl/rspm_evt.sv ***
// Purpose: sticky event status, mask and level interrupt
// Assumes: clr_in is a write-one-to-clear strobe
// Notes: a set in the clearing cycle wins
`timescale 1ns/100ps
module rspm_evt (
    input logic clk_in,
    input logic rst_in,
    input logic en_in,
    input logic [3:0] set_in,
    input logic [3:0] clr_in,
    input logic mask_wr_in,
    input logic [3:0] mask_in,
    output logic [3:0] status_out,
    output logic [3:0] mask_out,
    output logic irq_out
);
    logic [3:0] status_next;

    assign status_next = (status_out & ~clr_in) | set_in;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            status_out <= 4'h0;
            mask_out <= 4'h0;
            irq_out <= 1'b0;
        end else if (en_in) begin
            status_out <= status_next;
            if (mask_wr_in) begin
                mask_out <= mask_in;
            end
            irq_out <= |(status_next & (mask_wr_in ? mask_in : mask_out));
        end
    end
endmodule

// *** rtl/rspm_sar.sv ***
// Purpose: successive approximation sequencer for the 6-bit converter
// Assumes: cmp_in is high when the input is at or above the tap level
// Notes: tap_out picks the resistor-string tap under test
`timescale 1ns/100ps
module rspm_sar (
    input logic clk_in,
    input logic rst_in,
    input logic en_in,
    input logic abort_in,
    input logic start_in,
    input logic cmp_in,
    output logic [5:0] tap_out,
    output logic [5:0] result_out,
    output logic busy_out,
    output logic done_out
);
    logic [5:0] bit_reg;
    logic [5:0] tap_next;

    assign tap_next = cmp_in ? tap_out : (tap_out & ~bit_reg);

    always_ff @(posedge clk_in) begin
        if (rst_in || (en_in && abort_in)) begin
            bit_reg <= 6'h00;
            tap_out <= 6'h00;
            result_out <= 6'h00;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else if (en_in) begin
            done_out <= 1'b0;
            if (start_in && !busy_out) begin
                bit_reg <= rspm_pkg::ADC_MSB;
                tap_out <= rspm_pkg::ADC_MSB;
                busy_out <= 1'b1;
            end else if (busy_out) begin
                if (bit_reg == 6'h01) begin
                    result_out <= tap_next;
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                end else begin
                    tap_out <= tap_next | (bit_reg >> 1);
                    bit_reg <= bit_reg >> 1;
                end
            end
        end
    end

    sequence s_conv;
        busy_out[*6] ##1 (done_out && !busy_out);
    endsequence
    property p_sar_len;
        @(posedge clk_in) disable iff (rst_in || !en_in || abort_in)
        (start_in && !busy_out) |=> (tap_out == 6'h20) and s_conv;
    endproperty
    a_sar_len: assert property (p_sar_len) else $error("sar sequence wrong");
endmodule

// *** tb/rspm_supply_model.sv ***
// Purpose: model of the chip-enable pin, supply monitor and converter comparator
// Assumes: the bench raises requests on rising edges
// Notes: the comparator is analog, so it answers in the same cycle
`timescale 1ns/100ps
module rspm_supply_model (
    input wire logic clk_in,
    input wire logic ce_req_in,
    input wire logic por_req_in,
    input wire logic [5:0] level_in,
    input wire logic [5:0] tap_in,
    output logic chip_enable_out,
    output logic por_out,
    output logic cmp_out
);
    // pin and monitor settle one clock late, as a real pad path would
    always_ff @(posedge clk_in) begin
        chip_enable_out <= ce_req_in;
        por_out <= por_req_in;
    end
    assign cmp_out = (level_in >= tap_in);
endmodule

// *** tb/tb_reset_state_and_pin_mode_control.sv ***
// Purpose: bench for the reset state and pin mode controller
// Assumes: one wait state apb slave, events seen a clock after request
// Notes: waits use fixed settle time after each event
`timescale 1ns/100ps
module tb_reset_state_and_pin_mode_control;
    logic clk_in = 0, sys_rst_in = 1, psel = 0, pen = 0, pw = 0, stop = 0, en = 1;
    logic ce_req = 0, por_req = 0, ce, por, cmp, e, pready, perr, irq;
    logic [7:0] pa = 8'h00, gp, cn, ad;
    logic [31:0] pwd = 32'h0, prd, r;
    logic [5:0] tap, mux, level = 6'h2B;
    logic lsel, hsel, lpd, hpd, sw, osc, bk, rs, tc;
    logic [12:0] ra;
    logic [4:0] mt [4] = '{5'h06, 5'h12, 5'h13, 5'h0D};
    int fail_count = 0, n_tests = 0, cyc = 0, n_rst = 0, n0 = 0;
    rspm_top dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(en),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pw), .paddr_in(pa), .pwdata_in(pwd),
        .prdata_out(prd), .pready_out(pready), .pslverr_out(perr), .chip_enable_in(ce),
        .por_in(por), .clock_stop_in(stop), .adc_cmp_in(cmp), .adc_tap_out(tap),
        .adc_mux_out(mux), .pin_gpio_out(gp), .pin_count_out(cn), .pin_adc_out(ad),
        .lo_low_sel_out(lsel), .lo_high_sel_out(hsel), .lo_low_pd_out(lpd),
        .lo_high_pd_out(hpd), .swallow_en_out(sw), .osc_run_out(osc), .backup_out(bk),
        .restart_out(rs), .restart_addr_out(ra), .timer_carry_out(tc), .irq_out(irq));
    rspm_supply_model part_u (.clk_in(clk_in), .ce_req_in(ce_req), .por_req_in(por_req),
        .level_in(level), .tap_in(tap), .chip_enable_out(ce), .por_out(por), .cmp_out(cmp));
    initial begin
        forever #2.5 clk_in = ~clk_in;
    end
    task summarize;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (rs === 1'b1) n_rst <= n_rst + 1;
        if (cyc == 5000) begin
            fail_count++;
            summarize;
        end
    end
    task chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel <= 1;
        pw <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk_in);
        pen <= 1;
        do @(posedge clk_in); while (pready !== 1'b1);
        r = prd;
        e = perr;
        psel <= 0;
        pen <= 0;
    endtask
    task settle;
        repeat (4) @(posedge clk_in);
        #1;
    endtask
    // pin and monitor lag one clock in the model, so the stop pulse goes a clock later
    task ev(input logic c, input logic p, input logic s);
        @(posedge clk_in);
        ce_req <= c;
        por_req <= p;
        @(posedge clk_in);
        por_req <= 0;
        stop <= s;
        @(posedge clk_in);
        stop <= 0;
        settle;
    endtask
    initial begin
        repeat (4) @(posedge clk_in);
        sys_rst_in <= 0;
        settle;
        chk(gp, 8'hFF);
        chk({lpd, hpd}, 2'h3);
        chk(tc, rspm_pkg::TC_POR);
        chk(ra, rspm_pkg::RESTART_ADDR);
        ev(1, 0, 0);
        chk(tc, rspm_pkg::TC_CE);
        for (int i = 0; i < 8; i++) begin
            apb(1, rspm_pkg::OFS_CHAN, i);
            apb(0, rspm_pkg::OFS_CHAN, 0);
            chk(r, i);
            settle;
            chk(mux, i < 6 ? 6'h01 << i : 6'h00);
        end
        for (int i = 0; i < 4; i++) begin
            apb(1, rspm_pkg::OFS_MODE, i);
            settle;
            chk({lsel, hsel, lpd, hpd, sw}, mt[i]);
        end
        // with the clock enable low the chip-enable fall must not reach the outputs
        @(posedge clk_in);
        en <= 0;
        ev(0, 0, 0);
        chk({lpd, hpd}, 2'h2);
        @(posedge clk_in);
        en <= 1;
        apb(1, rspm_pkg::OFS_PINF, 32'h1002);
        ev(0, 0, 0);
        chk({lpd, hpd}, 2'h3);
        ev(1, 0, 0);
        chk({gp, cn, ad}, 24'hBE4001);
        chk({hsel, sw, tc}, 3'h7);
        apb(1, rspm_pkg::OFS_MASK, 32'h8);
        apb(1, rspm_pkg::OFS_ADC, 32'h1);
        repeat (12) @(posedge clk_in);
        apb(0, rspm_pkg::OFS_ADC, 0);
        chk(r[8:0], 9'h02B);
        chk(tap, 6'h2B);
        chk(irq, 1'b1);
        apb(0, rspm_pkg::OFS_STAT, 0);
        chk(r, 32'hA);
        apb(1, rspm_pkg::OFS_STAT, 32'hF);
        #1;
        chk(irq, 1'b0);
        ev(1, 0, 1);
        chk({gp, lsel, hsel, lpd, hpd, bk}, 13'h1FE6);
        ev(0, 0, 1);
        chk({bk, osc}, 2'h2);
        apb(0, rspm_pkg::OFS_SYS, 0);
        chk(r, 32'h3);
        // register writes are refused while in backup
        apb(1, rspm_pkg::OFS_CHAN, 32'h5);
        apb(0, rspm_pkg::OFS_CHAN, 0);
        chk(r, 32'h7);
        ev(1, 0, 0);
        chk({bk, osc}, 2'h1);
        apb(1, rspm_pkg::OFS_PINF, 32'h0002);
        n0 = n_rst;
        ev(1, 1, 0);
        chk({gp, tc}, 9'h1FE);
        chk(n_rst - n0, 1);
        apb(0, rspm_pkg::OFS_CHAN, 0);
        chk(r, 0);
        apb(0, 8'hF0, 0);
        chk(e, 1'b1);
        chk(r, 32'h0);
        summarize;
    end
endmodule
